// [pkg/cssc_pkg.sv]
// Constants and types shared by the clock source and start-up controller.
// Assumes configuration bits arrive as plain levels, 1 meaning unprogrammed.
package cssc_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CSSC_CNT_W = 16;
   localparam int CSSC_SYNC_W = 6;

   // ----------------------------------------------------------------
   // Clock source selection codes (as read: 1 = unprogrammed)
   // ----------------------------------------------------------------
   localparam logic [3:0] CSSC_SEL_LP_MIN = 4'h8;
   localparam logic [3:0] CSSC_SEL_FS_MIN = 4'h6;
   localparam logic [3:0] CSSC_SEL_LF_MIN = 4'h4;
   localparam logic [3:0] CSSC_SEL_RC128 = 4'h3;
   localparam logic [3:0] CSSC_SEL_RCCAL = 4'h2;
   localparam logic [3:0] CSSC_SEL_RESV = 4'h1;
   localparam logic [3:0] CSSC_SEL_EXT = 4'h0;

   // ----------------------------------------------------------------
   // Default configuration
   // ----------------------------------------------------------------
   localparam logic [3:0] CSSC_DEF_SEL = 4'h2;
   localparam logic [1:0] CSSC_DEF_SUT = 2'h2;
   localparam logic CSSC_DEF_DIV8 = 1'b0;

   // ----------------------------------------------------------------
   // Time-out counts in watchdog oscillator cycles
   // ----------------------------------------------------------------
   localparam int CSSC_TOUT_NONE = 0;
   localparam int CSSC_TOUT_SHORT = 512;
   localparam int CSSC_TOUT_LONG = 8192;

   // ----------------------------------------------------------------
   // Oscillator start-up counts in oscillator cycles
   // ----------------------------------------------------------------
   localparam int CSSC_SU_258 = 258;
   localparam int CSSC_SU_1K = 1024;
   localparam int CSSC_SU_16K = 16384;
   localparam int CSSC_SU_32K = 32768;
   localparam int CSSC_SU_FAST = 6;

   // ----------------------------------------------------------------
   // System clock divider
   // ----------------------------------------------------------------
   localparam int CSSC_DIV_W = 3;
   localparam logic [2:0] CSSC_DIV_LAST = 3'h7;

   // ----------------------------------------------------------------
   // Synchroniser lanes
   // ----------------------------------------------------------------
   localparam int CSSC_LN_WD = 0;
   localparam int CSSC_LN_OSC = 1;
   localparam int CSSC_LN_ASY = 2;
   localparam int CSSC_LN_EXTI = 3;
   localparam int CSSC_LN_USI = 4;
   localparam int CSSC_LN_TWI = 5;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CSSC_SRC_LP_XTAL,
      CSSC_SRC_FS_XTAL,
      CSSC_SRC_LF_XTAL,
      CSSC_SRC_RC128K,
      CSSC_SRC_RC_CAL,
      CSSC_SRC_EXT
   } cssc_src_type;

   typedef enum logic [1:0] {
      CSSC_TO_NONE,
      CSSC_TO_SHORT,
      CSSC_TO_LONG
   } cssc_tout_type;

endpackage : cssc_pkg

// [rtl/cssc_clk_gate.sv]
// Glitch-free clock gate for one clock domain.
// Assumes the enable comes from logic on the same clock.
`timescale 1ns/1ps
module cssc_clk_gate (
   // Clock in
   input wire logic i_clk,
   // Enable
   input wire logic i_en,
   // Gated clock out
   output logic o_gclk
);

   logic en_l;

   // ----------------------------------------------------------------
   // Latch transparent in the low phase only
   // ----------------------------------------------------------------
   // Enable can only change while the clock is low, so no runt pulse
   always_latch begin
      if (!i_clk) begin
         en_l <= i_en;
      end
   end

   assign o_gclk = i_clk & en_l;

endmodule : cssc_clk_gate

// [rtl/cssc_clock_ctrl.sv]
// Clock source selection, start-up reset sequencing and domain clock gating.
// Assumes oscillator and wake pins are asynchronous to i_clk_sys, which is
// the generated system clock; configuration bits are static straps.
//
// Functional notes
// - Codes 1111-1000 low power, 0111-0110 full swing, 0101-0100 low frequency crystal
// - 0011 internal 128 kHz RC, 0010 calibrated RC, 0000 external, 0001 reserved
// - Configuration bits read 1 unprogrammed, 0 programmed; decode uses that polarity
// - Default: calibrated RC, start-up code 10, time-out on, divide by eight
// - Internal reset held for a time-out after other reset sources release
// - Time-out counts 0, 512 or 8192 watchdog oscillator cycles
// - Counter on selected oscillator holds reset, then releases it
// - Start-up count depends on clock type, 6 up to 32K cycles
// - Reset start applies time-out and start-up; deep-sleep wake applies start-up only, shallow wake neither
// - Gated CPU clock domain; halting it stops the core
// - I/O clock domain; some external interrupts detected while it is halted
// - Serial start and two-wire address detection work with I/O clock halted
// - Flash clock runs whenever the CPU clock runs
// - Asynchronous timer clock from external pin keeps running in sleep
// - Converter clock can run while CPU and I/O clocks are halted
// - Unused domain clocks halt independently according to sleep mode
// - Divide-by-eight setting divides system clock by eight for the CPU, I/O, flash and converter domains
// - Low power and full swing crystal start-up count from low select bit and start-up bits
`timescale 1ns/1ps
module cssc_clock_ctrl
   import cssc_pkg::*;
#(
   parameter int P_TOUT_LONG = CSSC_TOUT_LONG,
   parameter int P_SU_16K = CSSC_SU_16K,
   parameter int P_SU_32K = CSSC_SU_32K
) (
   // System clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Configuration straps
   input wire logic [3:0] i_clock_source_select_bits,
   input wire logic [1:0] i_startup_time_bits,
   input wire logic i_divide_by_eight_setting,
   // Other reset sources
   input wire logic i_reset_sources_active,
   // Oscillator pins
   input wire logic i_wd_osc,
   input wire logic i_osc_lp_xtal,
   input wire logic i_osc_fs_xtal,
   input wire logic i_osc_lf_xtal,
   input wire logic i_osc_rc128k,
   input wire logic i_osc_rc_cal,
   input wire logic i_osc_ext,
   input wire logic i_asy_timer_osc,
   // Sleep control
   input wire logic i_sleep_req,
   input wire logic i_sleep_deep,
   input wire logic i_wake,
   input wire logic i_halt_cpu,
   input wire logic i_halt_io,
   input wire logic i_halt_adc,
   // Asynchronous wake sources
   input wire logic i_ext_int_async,
   input wire logic i_universal_serial_port_start,
   input wire logic i_two_wire_port_addr_match,
   // Domain clocks
   output logic o_clk_cpu,
   output logic o_clk_io,
   output logic o_clk_flash,
   output logic o_clk_adc,
   output logic o_clk_asy,
   // Status
   output logic o_internal_reset,
   output cssc_src_type o_clock_source,
   output logic o_config_error,
   output logic o_sleeping,
   output logic o_async_wake
);

   typedef enum logic [2:0] {
      ST_RESET,
      ST_TIMEOUT,
      ST_STARTUP,
      ST_RUN,
      ST_SLEEP
   } cssc_state_type;

   cssc_state_type state_r;
   logic [3:0] sel_r;
   logic [1:0] sut_r;
   logic div8_r;
   logic deep_r;
   logic cap_r;
   logic reset_r;
   logic err_r;
   cssc_src_type src_r;
   logic [CSSC_CNT_W-1:0] cnt_r;
   logic [CSSC_DIV_W-1:0] div_r;
   logic [CSSC_SYNC_W-1:0] s1_r;
   logic [CSSC_SYNC_W-1:0] s2_r;
   logic [CSSC_SYNC_W-1:0] s3_r;
   logic [CSSC_SYNC_W-1:0] stab_r;
   logic asy_r;
   logic [CSSC_SYNC_W-1:0] rise;
   logic [CSSC_SYNC_W-1:0] pins;
   cssc_src_type src_dec;
   cssc_tout_type tout_dec;
   logic err_dec;
   logic osc_sel;
   int su_cyc;
   int tout_cyc;
   logic [CSSC_CNT_W-1:0] su_m1;
   logic [CSSC_CNT_W-1:0] tout_m1;
   logic tout_zero;
   logic div_tick;
   logic async_evt;
   logic wake_any;
   logic en_cpu;
   logic en_io;
   logic en_flash;
   logic en_adc;

   // ----------------------------------------------------------------
   // Source decode
   // ----------------------------------------------------------------
   // Codes are taken as read from the straps: 1 unprogrammed, 0 programmed
   always_comb begin
      src_dec = CSSC_SRC_RC_CAL;
      err_dec = 1'b0;
      if (sel_r >= CSSC_SEL_LP_MIN) begin
         src_dec = CSSC_SRC_LP_XTAL;
      end else if (sel_r >= CSSC_SEL_FS_MIN) begin
         src_dec = CSSC_SRC_FS_XTAL;
      end else if (sel_r >= CSSC_SEL_LF_MIN) begin
         src_dec = CSSC_SRC_LF_XTAL;
      end else if (sel_r == CSSC_SEL_RC128) begin
         src_dec = CSSC_SRC_RC128K;
      end else if (sel_r == CSSC_SEL_RCCAL) begin
         src_dec = CSSC_SRC_RC_CAL;
      end else if (sel_r == CSSC_SEL_EXT) begin
         src_dec = CSSC_SRC_EXT;
      end else begin
         // Reserved code falls back to the calibrated RC and is flagged
         err_dec = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Start-up and time-out counts
   // ----------------------------------------------------------------
   always_comb begin
      su_cyc = CSSC_SU_FAST;
      tout_dec = CSSC_TO_LONG;
      tout_cyc = P_TOUT_LONG;
      if (src_dec == CSSC_SRC_LP_XTAL || src_dec == CSSC_SRC_FS_XTAL) begin
         unique case ({sel_r[0], sut_r})
            3'h0: begin su_cyc = CSSC_SU_258; tout_dec = CSSC_TO_SHORT; end
            3'h1: begin su_cyc = CSSC_SU_258; tout_dec = CSSC_TO_LONG; end
            3'h2: begin su_cyc = CSSC_SU_1K; tout_dec = CSSC_TO_NONE; end
            3'h3: begin su_cyc = CSSC_SU_1K; tout_dec = CSSC_TO_SHORT; end
            3'h4: begin su_cyc = CSSC_SU_1K; tout_dec = CSSC_TO_LONG; end
            3'h5: begin su_cyc = P_SU_16K; tout_dec = CSSC_TO_NONE; end
            3'h6: begin su_cyc = P_SU_16K; tout_dec = CSSC_TO_SHORT; end
            3'h7: begin su_cyc = P_SU_16K; tout_dec = CSSC_TO_LONG; end
         endcase
      end else begin
         su_cyc = (src_dec == CSSC_SRC_LF_XTAL) ? P_SU_32K : CSSC_SU_FAST;
         unique case (sut_r)
            2'h0: tout_dec = CSSC_TO_NONE;
            2'h1: tout_dec = CSSC_TO_SHORT;
            2'h2: tout_dec = CSSC_TO_LONG;
            2'h3: tout_dec = CSSC_TO_LONG;
         endcase
      end
      unique case (tout_dec)
         CSSC_TO_NONE: tout_cyc = CSSC_TOUT_NONE;
         CSSC_TO_SHORT: tout_cyc = CSSC_TOUT_SHORT;
         CSSC_TO_LONG: tout_cyc = P_TOUT_LONG;
      endcase
   end

   assign su_m1 = CSSC_CNT_W'(su_cyc - 1);
   assign tout_m1 = CSSC_CNT_W'(tout_cyc - 1);
   assign tout_zero = (tout_cyc == 0);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   always_comb begin
      osc_sel = i_osc_rc_cal;
      unique case (src_dec)
         CSSC_SRC_LP_XTAL: osc_sel = i_osc_lp_xtal;
         CSSC_SRC_FS_XTAL: osc_sel = i_osc_fs_xtal;
         CSSC_SRC_LF_XTAL: osc_sel = i_osc_lf_xtal;
         CSSC_SRC_RC128K: osc_sel = i_osc_rc128k;
         CSSC_SRC_RC_CAL: osc_sel = i_osc_rc_cal;
         CSSC_SRC_EXT: osc_sel = i_osc_ext;
      endcase
   end

   assign pins = {i_two_wire_port_addr_match, i_universal_serial_port_start,
                  i_ext_int_async, i_asy_timer_osc, osc_sel, i_wd_osc};

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change is accepted only once stages two and three agree
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         stab_r <= '0;
      end else begin
         for (int i = 0; i < CSSC_SYNC_W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               stab_r[i] <= s3_r[i];
            end
         end
      end
   end

   assign rise = s2_r & s3_r & ~stab_r;

   // ----------------------------------------------------------------
   // Configuration capture
   // ----------------------------------------------------------------
   // Straps are sampled while held in reset, never by the reset itself
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         sel_r <= CSSC_DEF_SEL;
         sut_r <= CSSC_DEF_SUT;
         div8_r <= CSSC_DEF_DIV8;
      end else if (state_r == ST_RESET) begin
         sel_r <= i_clock_source_select_bits;
         sut_r <= i_startup_time_bits;
         div8_r <= i_divide_by_eight_setting;
      end
   end

   // Straps held in sel_r are valid only after one capture in this reset
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         cap_r <= 1'b0;
      end else begin
         cap_r <= (state_r == ST_RESET);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         src_r <= CSSC_SRC_RC_CAL;
         err_r <= 1'b0;
      end else begin
         src_r <= src_dec;
         err_r <= err_dec;
      end
   end

   // ----------------------------------------------------------------
   // Start-up sequencer
   // ----------------------------------------------------------------
   assign async_evt = (stab_r[CSSC_LN_EXTI] | rise[CSSC_LN_USI]
                       | rise[CSSC_LN_TWI]) & (state_r == ST_SLEEP);
   assign wake_any = i_wake | async_evt;

   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         state_r <= ST_RESET;
         cnt_r <= '0;
         reset_r <= 1'b1;
         deep_r <= 1'b0;
      end else if (i_reset_sources_active) begin
         state_r <= ST_RESET;
         cnt_r <= '0;
         reset_r <= 1'b1;
      end else begin
         unique case (state_r)
            ST_RESET: begin
               cnt_r <= '0;
               // After i_rst the defaults would pick the time-out, so wait a capture
               if (cap_r) begin
                  state_r <= tout_zero ? ST_STARTUP : ST_TIMEOUT;
               end
            end
            ST_TIMEOUT: begin
               if (rise[CSSC_LN_WD]) begin
                  if (cnt_r == tout_m1) begin
                     cnt_r <= '0;
                     state_r <= ST_STARTUP;
                  end else begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            end
            ST_STARTUP: begin
               if (rise[CSSC_LN_OSC]) begin
                  if (cnt_r == su_m1) begin
                     cnt_r <= '0;
                     state_r <= ST_RUN;
                     reset_r <= 1'b0;
                  end else begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
            end
            ST_RUN: begin
               if (i_sleep_req) begin
                  state_r <= ST_SLEEP;
                  deep_r <= i_sleep_deep;
               end
            end
            ST_SLEEP: begin
               if (wake_any) begin
                  // Deep sleep restarts the oscillator, without the time-out
                  state_r <= deep_r ? ST_STARTUP : ST_RUN;
                  cnt_r <= '0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // System clock divider and domain enables
   // ----------------------------------------------------------------
   // Division is done by passing one pulse in eight through the gates
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // Setting reads 0 when programmed, and programmed means divide
   assign div_tick = div8_r || (div_r == CSSC_DIV_LAST);

   always_comb begin
      en_cpu = 1'b0;
      en_io = 1'b0;
      en_adc = 1'b0;
      if (state_r == ST_RUN) begin
         en_cpu = div_tick;
         en_io = div_tick;
         en_adc = div_tick;
      end else if (state_r == ST_SLEEP) begin
         en_cpu = div_tick && !i_halt_cpu;
         en_io = div_tick && !i_halt_io;
         en_adc = div_tick && !i_halt_adc;
      end
      en_flash = en_cpu;
   end

   cssc_clk_gate u_gate_cpu (.i_clk(i_clk_sys), .i_en(en_cpu), .o_gclk(o_clk_cpu));
   cssc_clk_gate u_gate_io (.i_clk(i_clk_sys), .i_en(en_io), .o_gclk(o_clk_io));
   cssc_clk_gate u_gate_flash (.i_clk(i_clk_sys), .i_en(en_flash), .o_gclk(o_clk_flash));
   cssc_clk_gate u_gate_adc (.i_clk(i_clk_sys), .i_en(en_adc), .o_gclk(o_clk_adc));

   // Timer oscillator follows its pin in every state, sleep included
   always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
         asy_r <= 1'b0;
      end else begin
         asy_r <= stab_r[CSSC_LN_ASY];
      end
   end

   assign o_clk_asy = asy_r;
   assign o_internal_reset = reset_r;
   assign o_clock_source = src_r;
   assign o_config_error = err_r;
   assign o_sleeping = (state_r == ST_SLEEP);
   assign o_async_wake = async_evt;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   chk_div_period: assert property (
      disable iff (i_rst || state_r == ST_RESET)
      (!div8_r && div_tick) |=> !div_tick [*7] ##1 div_tick)
      else $error("divided clock tick spacing is not eight");
   chk_reset_held: assert property (
      (state_r == ST_TIMEOUT || state_r == ST_RESET) |-> o_internal_reset)
      else $error("internal reset dropped during time-out");
   chk_tout_skip: assert property (
      (state_r == ST_RESET && !i_reset_sources_active && cap_r && tout_zero)
      |=> state_r == ST_STARTUP)
      else $error("zero time-out did not skip to start-up");
   chk_tout_end: assert property (
      (state_r == ST_TIMEOUT && !i_reset_sources_active && rise[CSSC_LN_WD]
       && cnt_r == tout_m1) |=> (state_r == ST_STARTUP && cnt_r == '0))
      else $error("time-out did not end on its last watchdog cycle");
   chk_release_edge: assert property (
      (state_r == ST_STARTUP && !i_reset_sources_active && rise[CSSC_LN_OSC]
       && cnt_r == su_m1) |=> (!o_internal_reset && state_r == ST_RUN))
      else $error("reset not released after start-up count");
   chk_wake_startup: assert property (
      (state_r == ST_SLEEP && deep_r && wake_any && !i_reset_sources_active)
      |=> (state_r == ST_STARTUP && !o_internal_reset))
      else $error("deep wake did not go straight to start-up");
   chk_flash_cpu: assert property (
      en_flash == en_cpu)
      else $error("flash clock enable differs from cpu clock enable");
   chk_cpu_halted: assert property (
      (state_r == ST_SLEEP && i_halt_cpu) |-> !en_cpu)
      else $error("cpu clock runs while halted");
   chk_adc_runs: assert property (
      (state_r == ST_SLEEP && !i_halt_adc && div_tick) |-> en_adc)
      else $error("converter clock stopped while requested");
   chk_reserved_code: assert property (
      (sel_r == CSSC_SEL_RESV) |=> (o_config_error && o_clock_source == CSSC_SRC_RC_CAL))
      else $error("reserved code not flagged");
   chk_async_wake: assert property (
      (state_r == ST_SLEEP && stab_r[CSSC_LN_EXTI]) |=> state_r != ST_SLEEP)
      else $error("asynchronous interrupt did not wake");
   chk_no_clk_reset: assert property (
      o_internal_reset |-> !(en_cpu || en_io || en_adc))
      else $error("domain clock enabled under internal reset");

   cov_por_run: cover property (state_r == ST_STARTUP ##1 state_r == ST_RUN);
   cov_deep_wake: cover property (state_r == ST_SLEEP && deep_r ##1 state_r == ST_STARTUP);
   cov_timeout: cover property (state_r == ST_TIMEOUT ##1 state_r == ST_STARTUP);
   cov_div8_run: cover property (state_r == ST_RUN && !div8_r && en_cpu);

endmodule : cssc_clock_ctrl

// [bench/cssc_osc_model.sv]
// Oscillator source model: one square wave shared by every oscillator pin.
// Assumes the block needs each pin level to last two system cycles; each lasts three here.
`timescale 1ns/1ps
module cssc_osc_model #(
   parameter int P_HALF = 3
) (
   // System clock
   input wire logic i_clk,
   // Oscillator level
   output logic o_pin
);
   int cnt = 0;
   initial o_pin = 1'b0;
   // Free-running, as a crystal or RC keeps swinging outside any frame
   always @(posedge i_clk) begin
      cnt <= (cnt == P_HALF - 1) ? 0 : cnt + 1;
      if (cnt == P_HALF - 1) begin
         o_pin <= ~o_pin;
      end
   end
endmodule : cssc_osc_model

// [bench/test_clock_source_and_startup_ctrl.sv]
// Self-checking bench for the clock source and start-up controller.
// Assumes one oscillator model drives all oscillator pins with a six cycle period.
`timescale 1ns/1ps
module test_clock_source_and_startup_ctrl;
   import cssc_pkg::*;
   // ----------
   // Signals
   // ----------
   localparam int P_LG = 16;
   localparam int P_S16 = 20;
   localparam int P_S32 = 24;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [3:0] sel = CSSC_DEF_SEL;
   logic [1:0] sut = CSSC_DEF_SUT;
   logic div = 1'b1;
   logic rsa = 1'b0, slp = 1'b0, deep = 1'b0, wake = 1'b0;
   logic [2:0] halt = 3'h0, aw = 3'h0;
   logic pin, c_cpu, c_io, c_fl, c_adc, c_asy, irst, cerr, sleeping, awk;
   cssc_src_type src;
   int miscompares = 0, cmp_count = 0, cycles = 0;
   int cnt [5];
   logic [16:0] lfsr = 17'h1_71e7;

   cssc_osc_model i_osc (.i_clk(i_clk_sys), .o_pin(pin));
   cssc_clock_ctrl #(.P_TOUT_LONG(P_LG), .P_SU_16K(P_S16), .P_SU_32K(P_S32)) i_dut (
      .i_clk_sys, .i_rst, .i_clock_source_select_bits(sel), .i_startup_time_bits(sut),
      .i_divide_by_eight_setting(div), .i_reset_sources_active(rsa), .i_wd_osc(pin),
      .i_osc_lp_xtal(pin), .i_osc_fs_xtal(pin), .i_osc_lf_xtal(pin), .i_osc_rc128k(pin),
      .i_osc_rc_cal(pin), .i_osc_ext(pin), .i_asy_timer_osc(pin), .i_sleep_req(slp),
      .i_sleep_deep(deep), .i_wake(wake), .i_halt_cpu(halt[0]), .i_halt_io(halt[1]),
      .i_halt_adc(halt[2]), .i_ext_int_async(aw[0]), .i_universal_serial_port_start(aw[1]),
      .i_two_wire_port_addr_match(aw[2]), .o_clk_cpu(c_cpu), .o_clk_io(c_io),
      .o_clk_flash(c_fl), .o_clk_adc(c_adc), .o_clk_asy(c_asy), .o_internal_reset(irst),
      .o_clock_source(src), .o_config_error(cerr), .o_sleeping(sleeping),
      .o_async_wake(awk));

   initial forever #5 i_clk_sys = ~i_clk_sys;
   always @(posedge c_cpu) cnt[0]++;
   always @(posedge c_io) cnt[1]++;
   always @(posedge c_fl) cnt[2]++;
   always @(posedge c_adc) cnt[3]++;
   always @(c_asy) cnt[4]++;
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         complete_run();
      end
   end
   // ----------
   // Helpers
   // ----------
   function automatic logic [3:0] rnd();
      lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
      return lfsr[3:0];
   endfunction : rnd
   function automatic cssc_src_type dec(logic [3:0] s);
      if (s >= CSSC_SEL_LP_MIN) return CSSC_SRC_LP_XTAL;
      if (s >= CSSC_SEL_FS_MIN) return CSSC_SRC_FS_XTAL;
      if (s >= CSSC_SEL_LF_MIN) return CSSC_SRC_LF_XTAL;
      if (s == CSSC_SEL_RC128) return CSSC_SRC_RC128K;
      if (s == CSSC_SEL_EXT) return CSSC_SRC_EXT;
      return CSSC_SRC_RC_CAL;
   endfunction : dec
   // Total watchdog plus oscillator rises before execution starts
   function automatic int edges(logic [3:0] s, logic [1:0] u);
      int v;
      int t [3];
      v = {s[0], u};
      t = '{CSSC_TOUT_SHORT, P_LG, CSSC_TOUT_NONE};
      if (s >= CSSC_SEL_FS_MIN) begin
         return t[v % 3] + ((v < 2) ? CSSC_SU_258 : (v < 5) ? CSSC_SU_1K : P_S16);
      end
      v = (u == 2'h0) ? CSSC_TOUT_NONE : (u == 2'h1) ? CSSC_TOUT_SHORT : P_LG;
      return v + ((s >= CSSC_SEL_LF_MIN) ? P_S32 : CSSC_SU_FAST);
   endfunction : edges
   task automatic check(logic ok, string m);
      cmp_count++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : check
   task automatic win(int n);
      @(negedge i_clk_sys);
      cnt = '{default: 0};
      repeat (n) @(negedge i_clk_sys);
   endtask : win
   // Reset through i_rst or through another reset source, then time release
   task automatic boot(logic by_src, int n);
      int c;
      @(posedge i_clk_sys);
      rsa <= by_src;
      i_rst <= ~by_src;
      repeat (3) @(posedge i_clk_sys);
      check(irst === 1'b1, "internal reset not held");
      rsa <= 1'b0;
      i_rst <= 1'b0;
      c = 0;
      while (irst !== 1'b0 && c < 6 * n + 40) begin
         @(negedge i_clk_sys);
         c++;
      end
      check(c >= 6 * n - 6 && c <= 6 * n + 30, "reset release time");
   endtask : boot
   task automatic complete_run();
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   // ----------
   // Scenarios
   // ----------
   initial begin
      int c;
      logic [3:0] r;
      logic seen;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      @(negedge i_clk_sys);
      check(irst === 1'b1 && src === CSSC_SRC_RC_CAL && cerr === 1'b0, "reset state");
      for (int k = 15; k >= 0; k--) begin
         r = rnd();
         @(posedge i_clk_sys);
         sel <= k[3:0];
         sut <= r[1:0];
         div <= r[2];
         boot(k[0], edges(k[3:0], r[1:0]));
         check(src === dec(k[3:0]) && cerr === (k == 1), "source decode");
         win(80);
         check(cnt[0] == (r[2] ? 80 : 10) && cnt[2] == cnt[0], "domain rate");
      end
      @(posedge i_clk_sys);
      sel <= CSSC_SEL_EXT;
      sut <= 2'h3;
      div <= 1'b1;
      boot(1'b0, edges(CSSC_SEL_EXT, 2'h3));
      // Deep sleep: CPU and I/O halted, converter and timer keep going
      @(posedge i_clk_sys);
      slp <= 1'b1;
      deep <= 1'b1;
      halt <= 3'h3;
      @(posedge i_clk_sys);
      slp <= 1'b0;
      win(40);
      check(sleeping === 1'b1 && cnt[0] == 0 && cnt[1] == 0, "halt");
      check(cnt[3] == 40 && cnt[4] > 8, "adc or timer stopped");
      @(posedge i_clk_sys);
      wake <= 1'b1;
      @(posedge i_clk_sys);
      wake <= 1'b0;
      cnt = '{default: 0};
      c = 0;
      while (cnt[0] == 0 && c < 80) begin
         @(negedge i_clk_sys);
         c++;
      end
      check(c >= 28 && c <= 64 && irst === 1'b0, "deep wake start-up only");
      // Shallow sleep left by each asynchronous wake source
      for (int w = 0; w < 3; w++) begin
         @(posedge i_clk_sys);
         slp <= 1'b1;
         deep <= 1'b0;
         halt <= 3'h7;
         @(posedge i_clk_sys);
         slp <= 1'b0;
         repeat (3) @(posedge i_clk_sys);
         check(sleeping === 1'b1, "sleep entry");
         aw <= 3'h1 << w;
         c = 0;
         seen = 1'b0;
         while (sleeping !== 1'b0 && c < 12) begin
            @(negedge i_clk_sys);
            seen = seen | (awk === 1'b1);
            c++;
         end
         check(c < 12 && seen === 1'b1, "async wake");
         @(posedge i_clk_sys);
         aw <= 3'h0;
         // Level interrupt must drain the synchroniser or it wakes the next sleep
         repeat (6) @(posedge i_clk_sys);
      end
      complete_run();
   end
endmodule : test_clock_source_and_startup_ctrl
